// ===== rtl/adcsf_pkg.sv
// Shared constants and state types of the converter serial frame and trigger logic
package adcsf_pkg;
  // ****************************************
  // Word layout
  // ****************************************
  localparam int WORD_W = 16;
  localparam int CMD_W = 4;
  localparam int CFG_W = 12;
  localparam int RES_W = 14;
  localparam logic [1:0] OUT_PAD = 2'h0;
  localparam logic [3:0] CNT_CMD_LAST = 4'h3;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [13:0] TWOS_FLIP = 14'h2000;
  // ****************************************
  // Commands and multiplexer codes
  // ****************************************
  localparam logic [3:0] CMD_TEST0 = 4'hB;
  localparam logic [3:0] CMD_TEST1 = 4'hC;
  localparam logic [3:0] CMD_TEST2 = 4'hD;
  localparam logic [3:0] MUX_TEST0 = 4'h8;
  localparam logic [3:0] MUX_TEST1 = 4'h9;
  localparam logic [3:0] MUX_TEST2 = 4'hA;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Order {serial clock, select, frame sync, serial in, trigger}
  localparam logic [4:0] SYNC_RST = 5'h0D;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h14;
  localparam int CTRL_TWOS = 0;
  localparam int CTRL_PDIFF = 1;
  localparam int CTRL_LEGACY = 2;
  localparam int CTRL_W = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACT = 1;
  localparam int STAT_CMD_LSB = 4;
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_CONV = 1;
  localparam int IRQ_W = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // ****************************************
  // States
  // ****************************************
  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_ARMED = 3'b010,
    SER_SHIFT = 3'b100
  } adcsf_ser_t;
  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_SAMPLE = 3'b010,
    CV_CONV = 3'b100
  } adcsf_cv_t;
endpackage

// ===== rtl/adcsf_reg_if.sv
// Interface between the serial core and its register file
`timescale 1ns/1ps
interface adcsf_reg_if;
  logic ev_frame;
  logic ev_conv;
  logic busy;
  logic frame_act;
  logic [3:0] last_cmd;
  logic [11:0] cfg_data;
  logic [13:0] result;
  logic twos;
  logic pdiff;
  logic legacy;
  modport core(output ev_frame, ev_conv, busy, frame_act, last_cmd, cfg_data, result,
    input twos, pdiff, legacy);
  modport regs(input ev_frame, ev_conv, busy, frame_act, last_cmd, cfg_data, result,
    output twos, pdiff, legacy);
endinterface

// ===== rtl/adcsf_sync.sv
// Two-flop synchronisers for the pin inputs
`timescale 1ns/1ps
module adcsf_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_r <= RST_VAL[i];
          sync_r <= RST_VAL[i];
        end else if (ce) begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate
endmodule

// ===== rtl/adcsf_apb.sv
// APB register file with sticky interrupt status and mask
`timescale 1ns/1ps
module adcsf_apb (
  // Clock
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Core
  adcsf_reg_if.regs rif
);
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [1:0] st_r, st_nxt, mask_r, mask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
  logic acc, wr;
  logic [31:0] stat_w;
  logic [1:0] ev, clr;

  always_comb begin
    acc = psel && penable;
    wr = acc && pready_r && pwrite && !pslverr_r;
    stat_w = 32'h0000_0000;
    stat_w[adcsf_pkg::STAT_BUSY] = rif.busy;
    stat_w[adcsf_pkg::STAT_ACT] = rif.frame_act;
    stat_w[adcsf_pkg::STAT_CMD_LSB +: 4] = rif.last_cmd;
    ev = 2'h0;
    ev[adcsf_pkg::IRQ_FRAME] = rif.ev_frame;
    ev[adcsf_pkg::IRQ_CONV] = rif.ev_conv;
    clr = 2'h0;
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    if (wr) begin
      unique case (paddr)
        adcsf_pkg::OFS_CTRL: ctrl_nxt = pwdata[adcsf_pkg::CTRL_W-1:0];
        adcsf_pkg::OFS_IRQ_ST: clr = pwdata[adcsf_pkg::IRQ_W-1:0];
        adcsf_pkg::OFS_IRQ_MASK: mask_nxt = pwdata[adcsf_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    st_nxt = (st_r & ~clr) | ev;
    irq_nxt = |(st_nxt & mask_nxt);
    pready_nxt = acc && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (acc && !pready_r) begin
      pslverr_nxt = 1'b0;
      unique case (paddr)
        adcsf_pkg::OFS_CTRL: prdata_nxt = 32'(ctrl_r);
        adcsf_pkg::OFS_STATUS: prdata_nxt = stat_w;
        adcsf_pkg::OFS_IRQ_ST: prdata_nxt = 32'(st_r);
        adcsf_pkg::OFS_IRQ_MASK: prdata_nxt = 32'(mask_r);
        adcsf_pkg::OFS_RESULT: prdata_nxt = 32'(rif.result);
        adcsf_pkg::OFS_CFG: prdata_nxt = 32'(rif.cfg_data);
        default: begin
          prdata_nxt = 32'h0000_0000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= adcsf_pkg::CTRL_RST;
      st_r <= adcsf_pkg::IRQ_RST;
      mask_r <= adcsf_pkg::IRQ_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      st_r <= st_nxt;
      mask_r <= mask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign rif.twos = ctrl_r[adcsf_pkg::CTRL_TWOS];
  assign rif.pdiff = ctrl_r[adcsf_pkg::CTRL_PDIFF];
  assign rif.legacy = ctrl_r[adcsf_pkg::CTRL_LEGACY];
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
endmodule

// ===== rtl/adcsf_top.sv
// Serial frame, conversion trigger and interrupt logic of a 14-bit sampling converter
`timescale 1ns/1ps
module adcsf_top #(
  parameter int NCH = 8,
  parameter int CONV_CYC = adcsf_pkg::CONV_CYC
) (
  // Clock, reset and enable
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  // Serial link pins
  input wire logic SERIAL_CLK,
  input wire logic SELECT_N,
  input wire logic FRAME_SYNC,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  output logic SERIAL_OUT_OE,
  // Trigger and status pins
  input wire logic CONVERSION_TRIGGER_N,
  output logic INT_N,
  output logic EOC_N,
  // Analog core
  input wire logic [13:0] ADC_CODE,
  output logic [3:0] MUX_SEL,
  output logic [3:0] MUX_NEG,
  output logic MUX_NEG_EN
);
  localparam logic [3:0] NCH_W = 4'(NCH);
  localparam logic [3:0] NCH_HALF = 4'(NCH / 2);
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1);

  adcsf_reg_if rif();

  // ****************************************
  // Pin synchronisers and edges
  // ****************************************
  logic s_sclk, s_cs_n, s_fs, s_sdi, s_cst_n;
  logic p_sclk_r, p_cs_r, p_fs_r, p_cst_r;
  logic sclk_rise, sclk_fall, cs_fall, fs_rise, cst_fall, cst_rise;

  adcsf_sync #(.W(5), .RST_VAL(adcsf_pkg::SYNC_RST)) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .ce(CE),
    .d({SERIAL_CLK, SELECT_N, FRAME_SYNC, SERIAL_IN, CONVERSION_TRIGGER_N}),
    .q({s_sclk, s_cs_n, s_fs, s_sdi, s_cst_n})
  );

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      p_sclk_r <= adcsf_pkg::SYNC_RST[4];
      p_cs_r <= adcsf_pkg::SYNC_RST[3];
      p_fs_r <= adcsf_pkg::SYNC_RST[2];
      p_cst_r <= adcsf_pkg::SYNC_RST[0];
    end else if (CE) begin
      p_sclk_r <= s_sclk;
      p_cs_r <= s_cs_n;
      p_fs_r <= s_fs;
      p_cst_r <= s_cst_n;
    end
  end

  assign sclk_rise = s_sclk && !p_sclk_r;
  assign sclk_fall = !s_sclk && p_sclk_r;
  assign cs_fall = !s_cs_n && p_cs_r;
  assign fs_rise = s_fs && !p_fs_r;
  assign cst_fall = !s_cst_n && p_cst_r;
  assign cst_rise = s_cst_n && !p_cst_r;

  // ****************************************
  // Serial frame engine
  // ****************************************
  adcsf_pkg::adcsf_ser_t ser_st_r, ser_st_nxt;
  logic fs_mode_r, fs_mode_nxt, oe_r, oe_nxt, sel_r, sel_nxt;
  logic [3:0] cnt_r, cnt_nxt, cmd_r, cmd_nxt, mux_sel_r, mux_sel_nxt;
  logic [3:0] mux_neg_r, mux_neg_nxt, c;
  logic neg_en_r, neg_en_nxt;
  logic [15:0] out_sh_r, out_sh_nxt, load_word;
  logic [10:0] in_sh_r, in_sh_nxt;
  logic [11:0] cfg_r, cfg_nxt;
  logic [13:0] result_r;
  logic frame_start, frame_end, conv_done;

  assign load_word = {result_r, adcsf_pkg::OUT_PAD};

  always_comb begin
    ser_st_nxt = ser_st_r;
    fs_mode_nxt = fs_mode_r;
    oe_nxt = oe_r;
    sel_nxt = sel_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    cfg_nxt = cfg_r;
    out_sh_nxt = out_sh_r;
    in_sh_nxt = in_sh_r;
    mux_sel_nxt = mux_sel_r;
    mux_neg_nxt = mux_neg_r;
    neg_en_nxt = neg_en_r;
    frame_start = 1'b0;
    frame_end = 1'b0;
    c = {in_sh_r[2:0], s_sdi};
    if (s_cs_n) begin
      ser_st_nxt = adcsf_pkg::SER_IDLE;
      oe_nxt = 1'b0;
    end else if (cs_fall && s_fs) begin
      fs_mode_nxt = 1'b0;
      frame_start = 1'b1;
    end else if (cs_fall) begin
      fs_mode_nxt = 1'b1;
      ser_st_nxt = adcsf_pkg::SER_ARMED;
      if (rif.legacy) begin
        out_sh_nxt = load_word;
        oe_nxt = 1'b1;
      end
    end else if (fs_mode_r && fs_rise) begin
      frame_start = 1'b1;
    end else if (ser_st_r == adcsf_pkg::SER_SHIFT) begin
      if (sclk_fall) begin
        in_sh_nxt = {in_sh_r[9:0], s_sdi};
        cnt_nxt = 4'(cnt_r + 4'h1);
        if (cnt_r == adcsf_pkg::CNT_CMD_LAST) begin
          cmd_nxt = c;
          sel_nxt = 1'b1;
          if (rif.pdiff && c < NCH_HALF) begin
            mux_sel_nxt = {1'b0, c[1:0], 1'b0};
            mux_neg_nxt = {1'b0, c[1:0], 1'b1};
            neg_en_nxt = 1'b1;
          end else if (!rif.pdiff && c < NCH_W) begin
            mux_sel_nxt = c;
            neg_en_nxt = 1'b0;
          end else if (c == adcsf_pkg::CMD_TEST0) begin
            mux_sel_nxt = adcsf_pkg::MUX_TEST0;
            neg_en_nxt = 1'b0;
          end else if (c == adcsf_pkg::CMD_TEST1) begin
            mux_sel_nxt = adcsf_pkg::MUX_TEST1;
            neg_en_nxt = 1'b0;
          end else if (c == adcsf_pkg::CMD_TEST2) begin
            mux_sel_nxt = adcsf_pkg::MUX_TEST2;
            neg_en_nxt = 1'b0;
          end else begin
            sel_nxt = 1'b0;
          end
        end
        if (cnt_r == adcsf_pkg::CNT_LAST) begin
          frame_end = 1'b1;
          oe_nxt = 1'b0;
          cfg_nxt = {in_sh_r, s_sdi};
          ser_st_nxt = fs_mode_r ? adcsf_pkg::SER_ARMED : adcsf_pkg::SER_IDLE;
        end
      end else if (sclk_rise && cnt_r != 4'h0) begin
        out_sh_nxt = {out_sh_r[14:0], 1'b0};
      end
    end
    if (frame_start) begin
      ser_st_nxt = adcsf_pkg::SER_SHIFT;
      cnt_nxt = 4'h0;
      sel_nxt = 1'b0;
      out_sh_nxt = load_word;
      oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ser_st_r <= adcsf_pkg::SER_IDLE;
      fs_mode_r <= 1'b0;
      oe_r <= 1'b0;
      sel_r <= 1'b0;
      cnt_r <= 4'h0;
      cmd_r <= 4'h0;
      cfg_r <= 12'h000;
      out_sh_r <= 16'h0000;
      in_sh_r <= 11'h000;
      mux_sel_r <= 4'h0;
      mux_neg_r <= 4'h0;
      neg_en_r <= 1'b0;
    end else if (CE) begin
      ser_st_r <= ser_st_nxt;
      fs_mode_r <= fs_mode_nxt;
      oe_r <= oe_nxt;
      sel_r <= sel_nxt;
      cnt_r <= cnt_nxt;
      cmd_r <= cmd_nxt;
      cfg_r <= cfg_nxt;
      out_sh_r <= out_sh_nxt;
      in_sh_r <= in_sh_nxt;
      mux_sel_r <= mux_sel_nxt;
      mux_neg_r <= mux_neg_nxt;
      neg_en_r <= neg_en_nxt;
    end
  end

  // ****************************************
  // Conversion timing and interrupt pin
  // ****************************************
  adcsf_pkg::adcsf_cv_t cv_st_r, cv_st_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic int_n_r, int_n_nxt, eoc_n_r, eoc_n_nxt;
  logic [13:0] result_nxt, coded;

  assign coded = rif.twos ? (ADC_CODE ^ adcsf_pkg::TWOS_FLIP) : ADC_CODE;

  always_comb begin
    cv_st_nxt = cv_st_r;
    tmr_nxt = tmr_r;
    int_n_nxt = int_n_r;
    eoc_n_nxt = eoc_n_r;
    result_nxt = result_r;
    conv_done = 1'b0;
    unique case (cv_st_r)
      adcsf_pkg::CV_IDLE: begin
        if (cst_fall) begin
          cv_st_nxt = adcsf_pkg::CV_SAMPLE;
        end else if (frame_end && sel_r) begin
          cv_st_nxt = adcsf_pkg::CV_CONV;
          tmr_nxt = CONV_LAST;
          eoc_n_nxt = 1'b0;
        end
      end
      adcsf_pkg::CV_SAMPLE: begin
        if (cst_rise) begin
          cv_st_nxt = adcsf_pkg::CV_CONV;
          tmr_nxt = CONV_LAST;
          eoc_n_nxt = 1'b0;
        end
      end
      adcsf_pkg::CV_CONV: begin
        if (tmr_r == 16'h0000) begin
          cv_st_nxt = adcsf_pkg::CV_IDLE;
          eoc_n_nxt = 1'b1;
          result_nxt = coded;
          conv_done = 1'b1;
        end else begin
          tmr_nxt = 16'(tmr_r - 16'h0001);
        end
      end
    endcase
    if (conv_done) begin
      int_n_nxt = 1'b0;
    end else if (cst_fall || frame_start || cs_fall) begin
      int_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cv_st_r <= adcsf_pkg::CV_IDLE;
      tmr_r <= 16'h0000;
      int_n_r <= 1'b1;
      eoc_n_r <= 1'b1;
      result_r <= 14'h0000;
    end else if (CE) begin
      cv_st_r <= cv_st_nxt;
      tmr_r <= tmr_nxt;
      int_n_r <= int_n_nxt;
      eoc_n_r <= eoc_n_nxt;
      result_r <= result_nxt;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  assign rif.ev_frame = CE && frame_end;
  assign rif.ev_conv = CE && conv_done;
  assign rif.busy = (cv_st_r == adcsf_pkg::CV_CONV);
  assign rif.frame_act = (ser_st_r == adcsf_pkg::SER_SHIFT);
  assign rif.last_cmd = cmd_r;
  assign rif.cfg_data = cfg_r;
  assign rif.result = result_r;

  adcsf_apb u_apb (
    .clk(MCLK),
    .rst_n(RST_N),
    .ce(CE),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .irq(IRQ),
    .rif(rif)
  );

  assign SERIAL_OUT = out_sh_r[15];
  assign SERIAL_OUT_OE = oe_r;
  assign INT_N = int_n_r;
  assign EOC_N = eoc_n_r;
  assign MUX_SEL = mux_sel_r;
  assign MUX_NEG = mux_neg_r;
  assign MUX_NEG_EN = neg_en_r;

  // ****************************************
  // Assertions
  // ****************************************
  logic [15:0] conv_age_r;
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      conv_age_r <= 16'h0000;
    end else if (CE) begin
      conv_age_r <= rif.busy ? 16'(conv_age_r + 16'h0001) : 16'h0000;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_desel_release: assert property (CE && s_cs_n |=> !SERIAL_OUT_OE)
    else $error("output driven while deselected");
  a_fs_msb_out: assert property (CE && fs_rise && fs_mode_r && !s_cs_n
    |=> SERIAL_OUT_OE && SERIAL_OUT == $past(result_r[13]))
    else $error("msb not presented after frame sync");
  a_fs_int_rel: assert property (CE && frame_start && !conv_done |=> INT_N)
    else $error("interrupt not released by frame start");
  a_trig_eoc_low: assert property (CE && cst_rise && cv_st_r == adcsf_pkg::CV_SAMPLE
    |=> !EOC_N && tmr_r == CONV_LAST)
    else $error("end of conversion not driven low");
  a_conv_length: assert property (conv_done |-> conv_age_r == CONV_LAST)
    else $error("conversion time wrong");
  a_done_int_low: assert property (CE && conv_done |=> !INT_N && EOC_N)
    else $error("interrupt not asserted at conversion end");
  a_trig_int_rel: assert property (CE && cst_fall && !conv_done |=> INT_N)
    else $error("interrupt not released by trigger fall");
  a_count_hiz: assert property (CE && sclk_fall && !s_cs_n && !cs_fall && !fs_rise
    && ser_st_r == adcsf_pkg::SER_SHIFT && cnt_r == adcsf_pkg::CNT_LAST
    |=> !SERIAL_OUT_OE)
    else $error("output not released after sixteen bits");
  a_twos_code: assert property (CE && conv_done && rif.twos
    |=> result_r == ($past(ADC_CODE) ^ adcsf_pkg::TWOS_FLIP))
    else $error("two's complement coding wrong");
  a_usb_code: assert property (CE && conv_done && !rif.twos
    |=> result_r == $past(ADC_CODE))
    else $error("straight binary coding wrong");
  a_pdiff_pair: assert property (CE && sclk_fall && !s_cs_n && !cs_fall && !fs_rise
    && ser_st_r == adcsf_pkg::SER_SHIFT && cnt_r == adcsf_pkg::CNT_CMD_LAST
    && rif.pdiff && c < NCH_HALF |=> MUX_NEG_EN && MUX_NEG == MUX_SEL + 4'h1)
    else $error("pseudodifferential pairing wrong");

  c_cs_frame: cover property (CE && cs_fall && s_fs ##[1:1000] rif.ev_frame);
  c_fs_frame: cover property (CE && fs_rise && fs_mode_r ##[1:1000] rif.ev_frame);
  c_trig_conv: cover property (CE && cst_rise && cv_st_r == adcsf_pkg::CV_SAMPLE
    ##[1:1000] conv_done);
  c_legacy_msb: cover property (CE && cs_fall && !s_fs && rif.legacy);
endmodule

// ===== bench/adcsf_host.sv
// Host serial port and conversion trigger model
`timescale 1ns/1ps
module adcsf_host (
  // Pins driven by the host
  output logic sclk,
  output logic sel_n,
  output logic fsync,
  output logic sin,
  output logic trig_n,
  // Pins seen by the host
  input wire logic sout,
  input wire logic oe,
  input wire logic int_n
);
  initial begin
    sclk = 1'b1;
    sel_n = 1'b1;
    fsync = 1'b1;
    sin = 1'b0;
    trig_n = 1'b1;
  end
  // ****************************************
  // Frame started by frame sync, 8 MHz clock held high between frames
  // ****************************************
  task automatic xfer(input logic s, input logic [15:0] di, output logic [15:0] dq,
    output logic irq_seen, output logic oe_any);
    fsync <= 1'b0;
    #62.5;
    sel_n <= s;
    #62.5;
    fsync <= 1'b1;
    sin <= di[15];
    oe_any = 1'b0;
    #62.5;
    irq_seen = int_n;
    for (int i = 15; i >= 0; i--) begin
      // A released output reads as the inverse of its last value
      dq[i] = oe ? sout : ~sout;
      oe_any = oe_any | oe;
      sclk <= 1'b0;
      #62.5;
      sclk <= 1'b1;
      fsync <= 1'b0;
      if (i > 0) begin
        sin <= di[i-1];
      end else begin
        sin <= ~di[0];
      end
      #62.5;
    end
  endtask
  // Sampling phase then conversion start; caller waits out the conversion
  task automatic conv(output logic irq_seen);
    trig_n <= 1'b0;
    #1000;
    irq_seen = int_n;
    trig_n <= 1'b1;
  endtask
endmodule

// ===== bench/adcsf_tb_top.sv
// Bench top: registers, trigger, coding and frame tests
`timescale 1ns/1ps
module adcsf_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [13:0] ADC_CODE = 14'h0000;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, IRQ, SCLK, SEL_N, FSYNC, SIN, SOUT, OE, TRIG_N, INT_N, EOC_N, NEG_EN;
  logic [3:0] MUX_SEL, MUX_NEG;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  adcsf_top #(.CONV_CYC(8)) i_adcsf_top (.MCLK(MCLK), .RST_N(RST_N), .CE(1'b1), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .SERIAL_CLK(SCLK), .SELECT_N(SEL_N),
    .FRAME_SYNC(FSYNC), .SERIAL_IN(SIN), .SERIAL_OUT(SOUT), .SERIAL_OUT_OE(OE),
    .CONVERSION_TRIGGER_N(TRIG_N), .INT_N(INT_N), .EOC_N(EOC_N), .ADC_CODE(ADC_CODE),
    .MUX_SEL(MUX_SEL), .MUX_NEG(MUX_NEG), .MUX_NEG_EN(NEG_EN));
  adcsf_host i_adcsf_host (.sclk(SCLK), .sel_n(SEL_N), .fsync(FSYNC), .sin(SIN),
    .trig_n(TRIG_N), .sout(SOUT), .oe(OE), .int_n(INT_N));
  initial begin
    forever begin
      #5 MCLK = ~MCLK;
    end
  end
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wait_lo(input logic on_int, output int n);
    n = 0;
    while ((on_int ? INT_N : EOC_N) !== 1'b0 && n < 100) begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 100) begin
      n_mismatch++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  logic [13:0] codes [3] = '{14'h0000, 14'h2000, 14'h3FFF};
  logic [3:0] cmds [6] = '{4'h0, 4'h5, 4'h7, 4'hB, 4'hC, 4'hD};
  logic [3:0] muxs [6] = '{4'h0, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA};
  initial begin
    logic [31:0] rd;
    logic er, ir, oa;
    logic [15:0] dq;
    logic [13:0] ex;
    int n;
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    apb(1'b0, 8'h18, 32'h0000_0000, rd, er);
    check("unmapped error", {31'h0, er}, 1);
    check("int idle", {31'h0, INT_N}, 1);
    apb(1'b1, adcsf_pkg::OFS_IRQ_MASK, 32'h0000_0003, rd, er);
    for (int i = 0; i < 6; i++) begin
      ADC_CODE <= codes[i % 3];
      ex = (i >= 3) ? {~codes[i % 3][13], codes[i % 3][12:0]} : codes[i % 3];
      apb(1'b1, adcsf_pkg::OFS_CTRL, {31'h0, i >= 3}, rd, er);
      i_adcsf_host.conv(ir);
      check("int release", {31'h0, ir}, 1);
      wait_lo(1'b0, n);
      check("eoc delay", {31'h0, n >= 3 && n <= 5}, 1);
      wait_lo(1'b1, n);
      check("int delay", n, 8);
      check("eoc end", {31'h0, EOC_N}, 1);
      apb(1'b0, adcsf_pkg::OFS_RESULT, 32'h0000_0000, rd, er);
      check("result", rd, {18'h0, ex});
      check("irq set", {31'h0, IRQ}, 1);
      apb(1'b1, adcsf_pkg::OFS_IRQ_ST, 32'h0000_0003, rd, er);
      repeat (3) @(posedge MCLK);
      check("irq clear", {31'h0, IRQ}, 0);
      i_adcsf_host.xfer(1'b0, {cmds[i], 12'h5A3}, dq, ir, oa);
      check("frame word", {18'h0, dq[15:2]}, {18'h0, ex});
      check("frame int", {31'h0, ir}, 1);
      check("oe after 16", {31'h0, OE}, 0);
      check("mux", {28'h0, MUX_SEL}, {28'h0, muxs[i]});
      wait_lo(1'b1, n);
      $display("coding and command test %0d done", i);
    end
    apb(1'b0, adcsf_pkg::OFS_CFG, 32'h0000_0000, rd, er);
    check("config bits", rd, 32'h0000_05A3);
    apb(1'b1, adcsf_pkg::OFS_CTRL, 32'h0000_0002, rd, er);
    i_adcsf_host.xfer(1'b0, 16'h1000, dq, ir, oa);
    check("pair", {23'h0, NEG_EN, MUX_SEL, MUX_NEG}, {23'h0, 1'b1, 4'h2, 4'h3});
    wait_lo(1'b1, n);
    i_adcsf_host.xfer(1'b1, 16'h0000, dq, ir, oa);
    check("deselected oe", {31'h0, oa}, 0);
    $display("pairing and deselect test done");
    apb(1'b1, adcsf_pkg::OFS_CTRL, 32'h0000_0004, rd, er);
    i_adcsf_host.sel_n <= 1'b0;
    repeat (6) @(posedge MCLK);
    check("legacy msb", {30'h0, OE, SOUT}, 32'h0000_0003);
    $display("legacy select test done");
    print_verdict();
  end
endmodule
